// ---- src/dtc_pkg.sv ----
// constants and helpers shared by the dual timer/counter block
//
// Operation
// - two-bit mode field selects one of four modes
// - count-source bit picks pin edges or ticks
// - count only when run and gate allow
// - gate bits sit at mode bits 7, 3
// - mode 0 counts thirteen bits, top three ignored
// - roll-over to zero sets the overflow flag
// - starting a timer never clears its counts
// - mode 1 counts all sixteen bits
// - mode 2 reloads low byte from high
// - timer 1 in mode 3 holds its count
// - timer 0 low byte keeps own controls, split
// - split high byte uses timer 1 run, flag
// - mode 3 toggling starts timer 1; baud stays
// - timer function counts once per machine cycle
// - pin sampled per machine cycle, fall counts
// - vectoring clears the flag; software may too
package dtc_pkg;
   // register addresses
   localparam logic [7:0] ADDR_CONTROL = 8'h88;
   localparam logic [7:0] ADDR_MODE    = 8'h89;
   localparam logic [7:0] ADDR_LOW_0   = 8'h8a;
   localparam logic [7:0] ADDR_LOW_1   = 8'h8b;
   localparam logic [7:0] ADDR_HIGH_0  = 8'h8c;
   localparam logic [7:0] ADDR_HIGH_1  = 8'h8d;
   localparam logic [7:0] ADDR_IRQ_ST  = 8'h90;
   localparam logic [7:0] ADDR_IRQ_MSK = 8'h91;
   // reset values
   localparam logic [7:0] RST_BYTE     = 8'h00;
   // control register field positions
   localparam int CTL_TF1 = 7;
   localparam int CTL_TR1 = 6;
   localparam int CTL_TF0 = 5;
   localparam int CTL_TR0 = 4;
   // mode register field positions
   localparam int MOD_GATE1 = 7;
   localparam int MOD_SRC1  = 6;
   localparam int MOD_SEL1  = 4;
   localparam int MOD_GATE0 = 3;
   localparam int MOD_SRC0  = 2;
   localparam int MOD_SEL0  = 0;
   // operating modes
   localparam logic [1:0] MODE_13BIT = 2'h0;
   localparam logic [1:0] MODE_16BIT = 2'h1;
   localparam logic [1:0] MODE_RELOAD = 2'h2;
   localparam logic [1:0] MODE_SPLIT = 2'h3;
   // oscillator periods per machine cycle
   localparam int MC_PERIODS = 12;
   localparam logic [3:0] MC_LAST = 4'(MC_PERIODS - 1);

   // one increment step: returns {overflow, high, low}
   function automatic logic [16:0] dtc_step(input logic [1:0] mode,
      input logic [7:0] hi, input logic [7:0] lo);
      logic [16:0] r;
      r = {1'b0, hi, lo};
      case (mode)
         MODE_13BIT: begin
            r[16:8] = (lo[4:0] == 5'h1f) ? {1'b0, hi} + 9'h001
                                         : {1'b0, hi};
            r[7:0]  = {lo[7:5], 5'(lo[4:0] + 5'h01)};
         end
         MODE_16BIT: r = {1'b0, hi, lo} + 17'h00001;
         MODE_RELOAD: begin
            r = (lo == 8'hff) ? {1'b1, hi, hi}
                              : {1'b0, hi, 8'(lo + 8'h01)};
         end
         default: r = {(lo == 8'hff), hi, 8'(lo + 8'h01)};
      endcase
      return r;
   endfunction
endpackage

// ---- src/dtc_pin_sample.sv ----
// pin synchroniser with once-per-machine-cycle fall detection
`timescale 1ns/1ps
module dtc_pin_sample
   import dtc_pkg::*;
(
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // pin and machine-cycle tick
   input  wire logic pin,
   input  wire logic tick,
   // synchronised level and fall pulse
   output logic      level,
   output logic      fall
);
   logic meta;    // first stage, read only by level
   logic sampled; // level taken at the previous tick

   // two-stage synchroniser; pin is asynchronous to clk
   always_ff @(posedge clk) begin
      if (rst) begin
         meta  <= 1'b0;
         level <= 1'b0;
      end else begin
         meta  <= pin;
         level <= meta;
      end
   end

   // high sample then low sample counts one fall
   always_ff @(posedge clk) begin
      if (rst) begin
         sampled <= 1'b0;
         fall    <= 1'b0;
      end else begin
         if (tick) sampled <= level;
         fall <= tick & sampled & ~level;
      end
   end

   chk_fall_on_tick: assert property (@(posedge clk)
      disable iff (rst) fall |-> $past(tick))
      else $error("fall not aligned");
   cov_fall: cover property (@(posedge clk) disable iff (rst) fall);
endmodule // dtc_pin_sample

// ---- src/dtc_irq.sv ----
// sticky overflow status with mask and level interrupt
`timescale 1ns/1ps
module dtc_irq
   import dtc_pkg::*;
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // overflow events, one per timer flag
   input  wire logic [1:0] event_in,
   // software access
   input  wire logic       wr_status,
   input  wire logic       wr_mask,
   input  wire logic [1:0] wdata,
   // state and interrupt
   output logic      [1:0] status,
   output logic      [1:0] mask,
   output logic            irq
);
   // write one clears; a same-cycle event keeps the bit set
   always_ff @(posedge clk) begin
      if (rst) begin
         status <= 2'h0;
      end else begin
         status <= (status & ~(wr_status ? wdata : 2'h0)) | event_in;
      end
   end

   // mask register, one enable per flag
   always_ff @(posedge clk) begin
      if (rst) begin
         mask <= 2'h0;
      end else if (wr_mask) begin
         mask <= wdata;
      end
   end

   // level output follows the unmasked status
   assign irq = |(status & mask);

   chk_set_wins: assert property (@(posedge clk)
      disable iff (rst) event_in[0] |=> status[0])
      else $error("event lost");
endmodule // dtc_irq

// ---- src/dtc_top.sv ----
// two-timer counter core with register port
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
module dtc_top
   import dtc_pkg::*;
(
   // clock and reset
   input  wire logic       CLK,
   input  wire logic       RST,
   // register port
   input  wire logic [7:0] ADDR,
   input  wire logic [7:0] WDATA,
   input  wire logic       WR,
   input  wire logic       RD,
   output logic      [7:0] RDATA,
   // interrupt vector acknowledges, one-cycle pulses
   input  wire logic       VECTOR_ACK_0,
   input  wire logic       VECTOR_ACK_1,
   // external pins
   input  wire logic       EVENT_INPUT_0,
   input  wire logic       EVENT_INPUT_1,
   input  wire logic       QUALIFY_PIN_0,
   input  wire logic       QUALIFY_PIN_1,
   // outputs
   output logic            IRQ,
   output logic            BAUD_TICK
);
   // machine-cycle divider
   logic [3:0]  mc_count;  // oscillator period within cycle
   logic        tick;      // one pulse per machine cycle
   // software registers
   logic [7:0]  timer_mode_config;   // gate, source, mode
   logic [7:0]  timer_control_flags; // flags, run bits
   logic [7:0]  count_low_0;
   logic [7:0]  count_high_0;
   logic [7:0]  count_low_1;
   logic [7:0]  count_high_1;
   // decoded fields
   logic [1:0]  mode_0;
   logic [1:0]  mode_1;
   logic        gate_0;
   logic        gate_1;
   logic        src_0;
   logic        src_1;
   logic        run_bit_0;
   logic        run_bit_1;
   logic        overflow_flag_0;
   logic        overflow_flag_1;
   // pin views
   logic        qual_0;    // synchronised gate pin levels
   logic        qual_1;
   logic        fall_0;    // counted falls on event pins
   logic        fall_1;
   // count enables and results
   logic        run_0;
   logic        run_1;
   logic        inc_0;
   logic        inc_1;
   logic        inc_0_high;
   logic [16:0] step_0;
   logic [16:0] step_1;
   logic [7:0]  next_low_0;
   logic [7:0]  next_high_0;
   logic [7:0]  next_low_1;
   logic [7:0]  next_high_1;
   logic        ovf_0;
   logic        ovf_0_high;
   logic        ovf_1;
   logic        set_flag_0;
   logic        set_flag_1;
   // write decode
   logic        wr_ctl;
   logic        wr_mod;
   logic        wr_l0;
   logic        wr_h0;
   logic        wr_l1;
   logic        wr_h1;
   // interrupt unit
   logic [1:0]  irq_status;
   logic [1:0]  irq_mask;

   // machine cycle is twelve oscillator periods
   always_ff @(posedge CLK) begin
      if (RST) begin
         mc_count <= 4'h0;
      end else if (mc_count == MC_LAST) begin
         mc_count <= 4'h0;
      end else begin
         mc_count <= 4'(mc_count + 4'h1);
      end
   end
   assign tick = (mc_count == MC_LAST);

   // event and gate pins all pass the synchroniser
   dtc_pin_sample u_event_0 (
      .clk   (CLK),
      .rst   (RST),
      .pin   (EVENT_INPUT_0),
      .tick  (tick),
      .level (),
      .fall  (fall_0)
   );
   dtc_pin_sample u_event_1 (
      .clk   (CLK),
      .rst   (RST),
      .pin   (EVENT_INPUT_1),
      .tick  (tick),
      .level (),
      .fall  (fall_1)
   );
   dtc_pin_sample u_qual_0 (
      .clk   (CLK),
      .rst   (RST),
      .pin   (QUALIFY_PIN_0),
      .tick  (tick),
      .level (qual_0),
      .fall  ()
   );
   dtc_pin_sample u_qual_1 (
      .clk   (CLK),
      .rst   (RST),
      .pin   (QUALIFY_PIN_1),
      .tick  (tick),
      .level (qual_1),
      .fall  ()
   );

   // address decode for writes
   assign wr_ctl = WR && (ADDR == ADDR_CONTROL);
   assign wr_mod = WR && (ADDR == ADDR_MODE);
   assign wr_l0  = WR && (ADDR == ADDR_LOW_0);
   assign wr_h0  = WR && (ADDR == ADDR_HIGH_0);
   assign wr_l1  = WR && (ADDR == ADDR_LOW_1);
   assign wr_h1  = WR && (ADDR == ADDR_HIGH_1);

   // field decode of the mode and control registers
   assign gate_1 = timer_mode_config[MOD_GATE1];
   assign gate_0 = timer_mode_config[MOD_GATE0];
   assign src_1  = timer_mode_config[MOD_SRC1];
   assign src_0  = timer_mode_config[MOD_SRC0];
   assign mode_1 = timer_mode_config[MOD_SEL1+:2];
   assign mode_0 = timer_mode_config[MOD_SEL0+:2];
   assign run_bit_0       = timer_control_flags[CTL_TR0];
   assign run_bit_1       = timer_control_flags[CTL_TR1];
   assign overflow_flag_0 = timer_control_flags[CTL_TF0];
   assign overflow_flag_1 = timer_control_flags[CTL_TF1];

   // run qualification: run bit and, if gated, a high gate pin
   assign run_0 = run_bit_0 && (!gate_0 || qual_0);
   // timer 1 in mode 3 acts as if stopped; with timer 0 split its run
   // bit belongs to the high byte, so only the mode starts timer 1
   assign run_1 = (run_bit_1 || mode_0 == MODE_SPLIT)
                  && (!gate_1 || qual_1)
                  && (mode_1 != MODE_SPLIT);

   // source select: falls on the pin or machine-cycle ticks
   assign inc_0 = run_0 && (src_0 ? fall_0 : tick);
   assign inc_1 = run_1 && (src_1 ? fall_1 : tick);
   // split high byte: ticks only, on timer 1's run bit
   assign inc_0_high = (mode_0 == MODE_SPLIT) && run_bit_1
                       && tick;

   // next count values; the split high byte steps apart
   always_comb begin
      step_0      = dtc_step(mode_0, count_high_0, count_low_0);
      step_1      = dtc_step(mode_1, count_high_1, count_low_1);
      next_low_0  = inc_0 ? step_0[7:0] : count_low_0;
      next_high_0 = inc_0 ? step_0[15:8] : count_high_0;
      if (mode_0 == MODE_SPLIT) begin
         next_high_0 = inc_0_high ? 8'(count_high_0 + 8'h01)
                                  : count_high_0;
      end
      next_low_1  = inc_1 ? step_1[7:0] : count_low_1;
      next_high_1 = inc_1 ? step_1[15:8] : count_high_1;
   end

   // overflow events from each counting stage
   assign ovf_0      = inc_0 && step_0[16];
   assign ovf_0_high = inc_0_high && (count_high_0 == 8'hff);
   assign ovf_1      = inc_1 && step_1[16];
   assign set_flag_0 = ovf_0;
   // split mode hands timer 1's flag to timer 0's high byte
   assign set_flag_1 = (mode_0 == MODE_SPLIT) ? ovf_0_high
                                              : ovf_1;

   // count bytes: a software write wins over any count
   always_ff @(posedge CLK) begin
      if (RST) begin
         count_low_0  <= RST_BYTE;
         count_high_0 <= RST_BYTE;
      end else begin
         count_low_0  <= wr_l0 ? WDATA : next_low_0;
         count_high_0 <= wr_h0 ? WDATA : next_high_0;
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         count_low_1  <= RST_BYTE;
         count_high_1 <= RST_BYTE;
      end else begin
         count_low_1  <= wr_l1 ? WDATA : next_low_1;
         count_high_1 <= wr_h1 ? WDATA : next_high_1;
      end
   end

   // mode register; a change takes effect the next cycle
   always_ff @(posedge CLK) begin
      if (RST) begin
         timer_mode_config <= RST_BYTE;
      end else if (wr_mod) begin
         timer_mode_config <= WDATA;
      end
   end

   // control register; run bits only gate, never clear counts
   always_ff @(posedge CLK) begin
      if (RST) begin
         timer_control_flags <= RST_BYTE;
      end else begin
         if (wr_ctl) begin
            timer_control_flags <= WDATA;
         end
         // vectoring clears a flag; a new overflow still wins
         if (VECTOR_ACK_0) begin
            timer_control_flags[CTL_TF0] <= 1'b0;
         end
         if (VECTOR_ACK_1) begin
            timer_control_flags[CTL_TF1] <= 1'b0;
         end
         if (set_flag_0) begin
            timer_control_flags[CTL_TF0] <= 1'b1;
         end
         if (set_flag_1) begin
            timer_control_flags[CTL_TF1] <= 1'b1;
         end
      end
   end

   // timer 1 overflow pulse stays available as baud source
   always_ff @(posedge CLK) begin
      if (RST) begin
         BAUD_TICK <= 1'b0;
      end else begin
         BAUD_TICK <= ovf_1;
      end
   end

   // sticky status, mask and interrupt line
   dtc_irq u_irq (
      .clk       (CLK),
      .rst       (RST),
      .event_in  ({set_flag_1, set_flag_0}),
      .wr_status (WR && (ADDR == ADDR_IRQ_ST)),
      .wr_mask   (WR && (ADDR == ADDR_IRQ_MSK)),
      .wdata     (WDATA[1:0]),
      .status    (irq_status),
      .mask      (irq_mask),
      .irq       (IRQ)
   );

   // read data one cycle after the strobe, zero otherwise
   always_ff @(posedge CLK) begin
      if (RST || !RD) begin
         RDATA <= 8'h00;
      end else begin
         case (ADDR)
            ADDR_CONTROL: RDATA <= timer_control_flags;
            ADDR_MODE:    RDATA <= timer_mode_config;
            ADDR_LOW_0:   RDATA <= count_low_0;
            ADDR_HIGH_0:  RDATA <= count_high_0;
            ADDR_LOW_1:   RDATA <= count_low_1;
            ADDR_HIGH_1:  RDATA <= count_high_1;
            ADDR_IRQ_ST:  RDATA <= {6'h00, irq_status};
            ADDR_IRQ_MSK: RDATA <= {6'h00, irq_mask};
            default:      RDATA <= 8'h00; // unmapped reads zero
         endcase
      end
   end

   // checks
   logic wr_t0;
   logic wr_t1;
   assign wr_t0 = wr_l0 || wr_h0;
   assign wr_t1 = wr_l1 || wr_h1;

   chk_tick_period: assert property (@(posedge CLK)
      disable iff (RST) tick |-> ##12 tick)
      else $error("machine cycle length");

   chk_write_wins: assert property (@(posedge CLK)
      disable iff (RST) wr_l0 |=> count_low_0 == $past(WDATA))
      else $error("write lost to count");

   chk_start_keeps: assert property (@(posedge CLK)
      disable iff (RST)
      wr_ctl && !run_bit_0 && WDATA[CTL_TR0] && !wr_t0
      |=> count_low_0 == $past(count_low_0)
          && count_high_0 == $past(count_high_0))
      else $error("start altered counts");

   chk_gate_hold: assert property (@(posedge CLK)
      disable iff (RST) !run_0 && !wr_l0 |=> $stable(count_low_0))
      else $error("counted while disabled");

   chk_mode1_wrap: assert property (@(posedge CLK)
      disable iff (RST)
      inc_0 && mode_0 == MODE_16BIT && !wr_t0
      && {count_high_0, count_low_0} == 16'hffff
      |=> {count_high_0, count_low_0} == 16'h0000 && overflow_flag_0)
      else $error("16-bit wrap");

   chk_mode2_reload: assert property (@(posedge CLK)
      disable iff (RST)
      inc_0 && mode_0 == MODE_RELOAD && count_low_0 == 8'hff && !wr_t0
      |=> count_low_0 == $past(count_high_0) && overflow_flag_0
          && $stable(count_high_0))
      else $error("reload wrong");

   chk_mode0_carry: assert property (@(posedge CLK)
      disable iff (RST)
      inc_0 && mode_0 == MODE_13BIT && count_low_0[4:0] == 5'h1f
      && count_high_0 != 8'hff && !wr_t0
      |=> count_high_0 == 8'($past(count_high_0) + 8'h01)
          && count_low_0[4:0] == 5'h00)
      else $error("prescaler carry");

   chk_t1_split_hold: assert property (@(posedge CLK)
      disable iff (RST) mode_1 == MODE_SPLIT && !wr_t1
      |=> $stable({count_high_1, count_low_1}))
      else $error("timer 1 ran in mode 3");

   // timer 1 must run on leaving mode 3 even with its run bit clear
   chk_t1_mode_start: assert property (@(posedge CLK)
      disable iff (RST)
      mode_0 == MODE_SPLIT && mode_1 == MODE_16BIT && !gate_1 && !src_1
      && tick && !wr_t1
      |=> !$stable({count_high_1, count_low_1}))
      else $error("timer 1 idle out of mode 3");

   chk_split_high: assert property (@(posedge CLK)
      disable iff (RST)
      mode_0 == MODE_SPLIT && run_bit_1 && tick && !wr_h0
      && count_high_0 == 8'hff
      |=> count_high_0 == 8'h00 && overflow_flag_1)
      else $error("split high overflow");

   chk_ack_clears: assert property (@(posedge CLK)
      disable iff (RST)
      VECTOR_ACK_0 && !set_flag_0 && !wr_ctl |=> !overflow_flag_0)
      else $error("ack kept flag");

   cov_reload: cover property (@(posedge CLK) disable iff (RST)
      inc_0 && mode_0 == MODE_RELOAD && count_low_0 == 8'hff);
   cov_split: cover property (@(posedge CLK) disable iff (RST)
      ovf_0_high);
   cov_irq: cover property (@(posedge CLK) disable iff (RST) IRQ);
   cov_baud: cover property (@(posedge CLK) disable iff (RST) BAUD_TICK);
endmodule // dtc_top

// ---- tb/dtc_pin_model.sv ----
// far-side model of the count pins and gate pins
`timescale 1ns/1ps
module dtc_pin_model (
   // clock
   input  wire logic clk,
   // pins toward the block
   output logic      event_0,
   output logic      event_1,
   output logic      qual_0,
   output logic      qual_1
);
   logic [1:0] ev = 2'b11; // count pins idle high, so no stray fall
   logic [1:0] ql = 2'b11; // gate pins start open
   assign event_0 = ev[0];
   assign event_1 = ev[1];
   assign qual_0  = ql[0];
   assign qual_1  = ql[1];
   // n falls; each level held for hold cycles, over one machine cycle
   task automatic pulse(input int idx, input int n, input int hold);
      repeat (n) begin
         @(posedge clk);
         ev[idx] <= 1'b0;
         repeat (hold) @(posedge clk);
         ev[idx] <= 1'b1;
         repeat (hold - 1) @(posedge clk);
      end
   endtask
   // gate level change, made just after an edge
   task automatic gate(input int idx, input logic lvl);
      @(posedge clk);
      ql[idx] <= lvl;
   endtask
endmodule // dtc_pin_model

// ---- tb/tb_dual_timer_counter_modes.sv ----
// self-checking bench for the dual timer/counter block
`timescale 1ns/1ps
module tb_dual_timer_counter_modes;
   import dtc_pkg::*;
   localparam int LIMIT = 4000; // cycles, about four times the planned run
   // design side
   logic       clk;
   logic       rst;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic       wr;
   logic       rd;
   logic [7:0] rdata;
   logic       ack_0;
   logic       ack_1;
   logic       ev_0;
   logic       ev_1;
   logic       ql_0;
   logic       ql_1;
   logic       irq;
   logic       baud;
   // scoreboard and counts
   logic [7:0] exp_q[$];        // expected read data, oldest first
   string      name_q[$];       // what each read is
   logic       rd_seen = 1'b0;  // a read was taken at the last edge
   int         bad_count = 0;
   int         checks = 0;
   int         cycles = 0;
   int         seed;
   logic [7:0] v;
   logic [7:0] baud_n = 8'h00;  // timer 1 overflow pulses seen
   // every address; the last one is unmapped
   logic [7:0] all_map[9] = '{ADDR_CONTROL, ADDR_MODE, ADDR_LOW_0,
      ADDR_LOW_1, ADDR_HIGH_0, ADDR_HIGH_1, ADDR_IRQ_ST, ADDR_IRQ_MSK,
      8'h8e};
   // mode field, preload low/high, expected low/high after three ticks
   logic [7:0] tbl[3][5] = '{'{8'h00, 8'hfe, 8'hff, 8'he1, 8'h00},
                             '{8'h11, 8'hfe, 8'hff, 8'h01, 8'h00},
                             '{8'h22, 8'hfe, 8'h80, 8'h81, 8'h80}};

   dtc_top i_dut (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata),
      .WR(wr), .RD(rd), .RDATA(rdata), .VECTOR_ACK_0(ack_0),
      .VECTOR_ACK_1(ack_1), .EVENT_INPUT_0(ev_0), .EVENT_INPUT_1(ev_1),
      .QUALIFY_PIN_0(ql_0), .QUALIFY_PIN_1(ql_1), .IRQ(irq),
      .BAUD_TICK(baud));
   dtc_pin_model i_pins (.clk(clk), .event_0(ev_0), .event_1(ev_1),
      .qual_0(ql_0), .qual_1(ql_1));

   // 25 MHz clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // read data is judged in the one cycle where it stands
   always @(posedge clk) begin
      if (rd_seen === 1'b1)
         check_byte(name_q.pop_front(), exp_q.pop_front(), rdata);
      rd_seen <= rd;
      cycles  <= cycles + 1;
      if (baud === 1'b1)
         baud_n <= baud_n + 8'h01;
      if (cycles == LIMIT) begin // a hang ends the run as a failure
         bad_count++;
         give_verdict();
      end
   end

   task automatic check_byte(input string n, input logic [7:0] e,
                             input logic [7:0] g);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected %s: expected %h seen %h", n, e, g);
      end
   endtask

   task automatic check_bit(input string n, input logic e, input logic g);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected %s: expected %b seen %b", n, e, g);
      end
   endtask

   // one-cycle write strobe
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask

   // one-cycle read strobe; the expectation is queued first
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] e,
                         input string n);
      exp_q.push_back(e);
      name_q.push_back(n);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
   endtask

   // mode and all four count bytes, with stale events cleared
   task automatic load(input logic [7:0] m, input logic [7:0] l0,
      input logic [7:0] h0, input logic [7:0] l1, input logic [7:0] h1);
      wr_reg(ADDR_MODE, m);
      wr_reg(ADDR_LOW_0, l0);
      wr_reg(ADDR_HIGH_0, h0);
      wr_reg(ADDR_LOW_1, l1);
      wr_reg(ADDR_HIGH_1, h1);
      wr_reg(ADDR_IRQ_ST, 8'h03);
   endtask

   // start and stop writes land 12n cycles apart: exactly n ticks
   // whatever the divider phase, so no tick alignment is needed
   task automatic run(input logic [7:0] ctl, input int n);
      wr_reg(ADDR_CONTROL, ctl);
      repeat (MC_PERIODS * n - 2) @(posedge clk);
      wr_reg(ADDR_CONTROL, 8'h00);
   endtask

   // one-cycle vector acknowledge
   task automatic ack(input int idx);
      @(posedge clk);
      {ack_1, ack_0} <= 2'(2'b01 << idx);
      @(posedge clk);
      {ack_1, ack_0} <= 2'b00;
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // main sequence
   initial begin
      seed  = 20082;
      rst   = 1'b1;
      addr  = 8'h00;
      wdata = 8'h00;
      wr    = 1'b0;
      rd    = 1'b0;
      ack_0 = 1'b0;
      ack_1 = 1'b0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      // reset values; unmapped write ignored, unmapped read is zero
      wr_reg(8'h8e, 8'hff);
      foreach (all_map[i])
         rd_reg(all_map[i], RST_BYTE, "reset value");
      $display("test reset done");
      // count bytes take random software writes whole
      for (int i = 2; i < 6; i++) begin
         v = 8'($random(seed));
         wr_reg(all_map[i], v);
         rd_reg(all_map[i], v, "count byte");
      end
      wr_reg(ADDR_IRQ_MSK, 8'hff);
      rd_reg(ADDR_IRQ_MSK, 8'h03, "mask width");
      $display("test access done");
      // modes 0 to 2 on both timers, three ticks each
      foreach (tbl[i]) begin
         load(tbl[i][0], tbl[i][1], tbl[i][2], tbl[i][1], tbl[i][2]);
         run(8'h50, 3);
         rd_reg(ADDR_LOW_0, tbl[i][3], "low 0");
         rd_reg(ADDR_HIGH_0, tbl[i][4], "high 0");
         rd_reg(ADDR_LOW_1, tbl[i][3], "low 1");
         rd_reg(ADDR_HIGH_1, tbl[i][4], "high 1");
         rd_reg(ADDR_IRQ_ST, 8'h03, "overflow status");
      end
      $display("test modes done");
      // interrupt masked, raised, then cleared by a one
      wr_reg(ADDR_IRQ_MSK, 8'h00);
      @(negedge clk);
      check_bit("irq masked", 1'b0, irq);
      wr_reg(ADDR_IRQ_MSK, 8'h02);
      @(negedge clk);
      check_bit("irq raised", 1'b1, irq);
      wr_reg(ADDR_IRQ_ST, 8'h02);
      @(negedge clk);
      check_bit("irq cleared", 1'b0, irq);
      rd_reg(ADDR_IRQ_ST, 8'h01, "status left");
      $display("test interrupt done");
      // software sets both flags; each ack clears only its own
      wr_reg(ADDR_CONTROL, 8'ha0);
      ack(0);
      rd_reg(ADDR_CONTROL, 8'h80, "flag after ack 0");
      ack(1);
      rd_reg(ADDR_CONTROL, 8'h00, "flag after ack 1");
      $display("test ack done");
      // each gate bit listens to its own pin only
      i_pins.gate(0, 1'b0);
      load(8'h99, 8'h00, 8'h00, 8'h00, 8'h00);
      run(8'h50, 3);
      rd_reg(ADDR_LOW_0, 8'h00, "gated low 0");
      rd_reg(ADDR_LOW_1, 8'h03, "open low 1");
      i_pins.gate(0, 1'b1);
      i_pins.gate(1, 1'b0);
      repeat (4) @(posedge clk); // pin synchroniser delay
      run(8'h50, 3);
      rd_reg(ADDR_LOW_0, 8'h03, "open low 0");
      rd_reg(ADDR_LOW_1, 8'h03, "gated low 1");
      $display("test gate done");
      // counter function, prompt pin on timer 0, slow on timer 1
      load(8'h55, 8'h00, 8'h00, 8'h00, 8'h00);
      wr_reg(ADDR_CONTROL, 8'h50);
      i_pins.pulse(0, 5, 16);
      i_pins.pulse(1, 3, 40);
      repeat (40) @(posedge clk);
      wr_reg(ADDR_CONTROL, 8'h00);
      rd_reg(ADDR_LOW_0, 8'h05, "pin count 0");
      rd_reg(ADDR_LOW_1, 8'h03, "pin count 1");
      $display("test counter done");
      // split timer 0; timer 1 frozen in its own mode 3
      load(8'h33, 8'hfe, 8'hfe, 8'h55, 8'haa);
      run(8'h50, 3);
      rd_reg(ADDR_LOW_0, 8'h01, "split low");
      rd_reg(ADDR_HIGH_0, 8'h01, "split high");
      rd_reg(ADDR_LOW_1, 8'h55, "held low 1");
      rd_reg(ADDR_HIGH_1, 8'haa, "held high 1");
      rd_reg(ADDR_IRQ_ST, 8'h03, "split flags");
      // run bits clear: leaving mode 3 alone starts timer 1 for
      // exactly three ticks, and its overflow feeds the baud pulse
      load(8'h33, 8'h00, 8'h00, 8'hff, 8'hff);
      v = baud_n;
      wr_reg(ADDR_MODE, 8'h13);
      repeat (MC_PERIODS * 3 - 2) @(posedge clk);
      wr_reg(ADDR_MODE, 8'h33);
      rd_reg(ADDR_LOW_1, 8'h02, "baud low 1");
      rd_reg(ADDR_HIGH_1, 8'h00, "baud high 1");
      rd_reg(ADDR_HIGH_0, 8'h00, "split high idle");
      rd_reg(ADDR_IRQ_ST, 8'h00, "no timer 1 flag");
      check_byte("baud pulses", 8'h01, 8'(baud_n - v));
      $display("test split done");
      repeat (3) @(posedge clk);
      give_verdict();
   end
endmodule // tb_dual_timer_counter_modes
